//--- rtl/tst_pkg.sv
// Overview of operation
// - Strobe every 8 (short) or 16 (long) cycles.
// - Strobe one cycle wide, rising edge starts slice.
// - One system clock for all timing logic.
// - Up to four event words moved per slice.
// - Forward clock copy aligned to output data.
// - Forward strobe copy aligned to output data.
// - One event word transfer occupies one slice.
// - Only same-slice words are ever paired.
// - Each pipeline stage finishes within one slice.
// - Long words twice as wide; short halves dead time.
// - Eight units, 28 pairs, 16 events per pair.
// - Strobe made locally or followed from upstream.
// - Incoming link clock regenerated by board PLL.
// - Combined controller also does coincidence processing.
package tst_pkg;

	localparam int SYS_CLOCK_MHZ   = 80;
	localparam int LANES           = 4;
	localparam int WORD_W          = 32;
	localparam int SHORT_WORD_W    = 16;
	localparam int TAG_W           = 1;
	localparam int FIFO_W          = WORD_W + TAG_W;
	localparam int FIFO_DEPTH      = 4;
	localparam int UNITS           = 8;
	localparam int UNIT_W          = 3;
	localparam int UNIT_LSB        = 0;
	localparam int PAIRS           = 28;
	localparam int PAIR_W          = 5;
	localparam int MAX_PER_PAIR    = 16;
	localparam int COUNT_W         = 5;
	localparam int LANE_CNT_W      = 3;
	localparam int COINC_W         = 3;
	localparam int PIN_COUNT       = 4;

	localparam logic [COUNT_W-1:0]    SHORT_SLICE_CYCLES = 5'h08;
	localparam logic [COUNT_W-1:0]    LONG_SLICE_CYCLES  = 5'h10;
	localparam logic [COUNT_W-1:0]    COUNT_RESET        = 5'h00;
	localparam logic [LANE_CNT_W-1:0] LANES_FULL         = 3'h4;

	localparam int PIN_LONG     = 0;
	localparam int PIN_RUN      = 1;
	localparam int PIN_MASTER   = 2;
	localparam int PIN_COMBINED = 3;

	typedef enum logic [1:0] {
		TST_GEN_IDLE = 2'b01,
		TST_GEN_RUN  = 2'b10
	} tst_gen_state_t;

	typedef enum logic [1:0] {
		TST_RX_IDLE = 2'b01,
		TST_RX_WAIT = 2'b10
	} tst_rx_state_t;

	// Maps an ordered unit pair a < b onto 0 .. PAIRS-1.
	function automatic logic [PAIR_W-1:0] tst_pair_index(input logic [UNIT_W-1:0] a, input logic [UNIT_W-1:0] b);
		logic [7:0] ia;
		logic [7:0] ib;
		logic [7:0] base;
		ia   = {5'h00, a};
		ib   = {5'h00, b};
		base = 8'(8'h07 * ia - ((ia * (ia - 8'h01)) >> 1));
		return PAIR_W'(base + ib - ia - 8'h01);
	endfunction : tst_pair_index

endpackage : tst_pkg

//--- rtl/tst_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tst_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : tst_stream_if
`default_nettype wire

//--- rtl/tst_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tst_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic i_clock,
	input  wire logic i_rstn,
	tst_stream_if.snk wr,
	tst_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   fill;
	logic [W-1:0]  head;

	wire do_write = wr.valid && wr.ready;
	wire do_read  = rd.valid && rd.ready;

	assign wr.ready = (fill != (AW+1)'(DEPTH));
	assign rd.valid = (fill != '0);
	assign head     = mem[rd_ptr];
	assign rd.data  = head;

	always_ff @(posedge i_clock) begin
		if (do_write) begin
			mem[wr_ptr] <= wr.data;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (do_write) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (do_read) begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
			fill <= (AW+1)'(fill + {{AW{1'b0}}, do_write} - {{AW{1'b0}}, do_read});
		end
	end
endmodule : tst_fifo
`default_nettype wire

//--- rtl/tst_top.sv
`timescale 1ns/1ps
`default_nettype none
module tst_top (
	input  wire logic                                       i_clock,
	input  wire logic                                       i_rstn,
	input  wire logic                                       i_link_clock,
	input  wire logic                                       i_long_mode,
	input  wire logic                                       i_run,
	input  wire logic                                       i_timing_master,
	input  wire logic                                       i_combined_role,
	input  wire logic                                       i_link_strobe,
	input  wire logic                                       i_link_valid,
	input  wire logic [tst_pkg::WORD_W-1:0]                 i_link_word,
	output logic                                            o_link_ready,
	output logic                                            o_slice_strobe,
	output logic                                            o_fwd_clock,
	output logic                                            o_fwd_strobe,
	output logic [tst_pkg::LANES-1:0]                       o_tx_valid,
	output logic [tst_pkg::LANES*tst_pkg::WORD_W-1:0]       o_tx_word,
	output logic                                            o_long_active,
	output logic [tst_pkg::COUNT_W-1:0]                     o_dead_cycles,
	output logic [tst_pkg::PAIRS-1:0]                       o_pair_hit,
	output logic [tst_pkg::PAIRS*tst_pkg::COUNT_W-1:0]      o_pair_count,
	output logic [tst_pkg::COINC_W-1:0]                     o_coinc_count
);

	// ------------------------------------------------------------------
	// Link clock domain: receive words and the upstream boundary strobe.
	// ------------------------------------------------------------------

	// The link clock arrives already cleaned by the board PLL.
	tst_pkg::tst_rx_state_t            rx_state;
	logic [tst_pkg::WORD_W-1:0]        rx_word;
	logic [tst_pkg::TAG_W-1:0]         rx_tag;
	logic [tst_pkg::TAG_W-1:0]         link_tag;
	logic                              rx_req;
	logic                              rx_ack_s1;
	logic                              rx_ack_s2;
	logic                              link_ready;
	logic                              link_bound_tgl;
	logic                              sys_ack;

	wire rx_take = (rx_state == tst_pkg::TST_RX_IDLE) && i_link_valid && link_ready;
	wire rx_done = (rx_state == tst_pkg::TST_RX_WAIT) && (rx_ack_s2 == rx_req);
	wire [tst_pkg::TAG_W-1:0] next_link_tag = i_link_strobe ? ~link_tag : link_tag;

	always_ff @(posedge i_link_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_ack_s1 <= 1'b0;
			rx_ack_s2 <= 1'b0;
		end else begin
			rx_ack_s1 <= sys_ack;
			rx_ack_s2 <= rx_ack_s1;
		end
	end

	// Words are tagged with the upstream slice they belong to.
	always_ff @(posedge i_link_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			link_tag       <= '0;
			link_bound_tgl <= 1'b0;
		end else begin
			link_tag       <= next_link_tag;
			link_bound_tgl <= link_bound_tgl ^ i_link_strobe;
		end
	end

	// One word is held per handshake; the source stalls on o_link_ready.
	always_ff @(posedge i_link_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_state   <= tst_pkg::TST_RX_IDLE;
			rx_word    <= '0;
			rx_tag     <= '0;
			rx_req     <= 1'b0;
			link_ready <= 1'b1;
		end else begin
			unique case (rx_state)
				tst_pkg::TST_RX_IDLE: begin
					if (rx_take) begin
						rx_word    <= i_link_word;
						rx_tag     <= next_link_tag;
						rx_req     <= ~rx_req;
						link_ready <= 1'b0;
						rx_state   <= tst_pkg::TST_RX_WAIT;
					end
				end
				tst_pkg::TST_RX_WAIT: begin
					if (rx_done) begin
						link_ready <= 1'b1;
						rx_state   <= tst_pkg::TST_RX_IDLE;
					end
				end
			endcase
		end
	end

	assign o_link_ready = link_ready;

	// ------------------------------------------------------------------
	// System clock domain.
	// ------------------------------------------------------------------

	logic [tst_pkg::PIN_COUNT-1:0] pin_s1;
	logic [tst_pkg::PIN_COUNT-1:0] pin_s2;
	logic                          req_s1;
	logic                          req_s2;
	logic                          bound_s1;
	logic                          bound_s2;
	logic                          bound_s3;

	wire [tst_pkg::PIN_COUNT-1:0] pin_raw = {i_combined_role, i_timing_master, i_run, i_long_mode};

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_s1   <= '0;
			pin_s2   <= '0;
			req_s1   <= 1'b0;
			req_s2   <= 1'b0;
			bound_s1 <= 1'b0;
			bound_s2 <= 1'b0;
			bound_s3 <= 1'b0;
		end else begin
			pin_s1   <= pin_raw;
			pin_s2   <= pin_s1;
			req_s1   <= rx_req;
			req_s2   <= req_s1;
			bound_s1 <= link_bound_tgl;
			bound_s2 <= bound_s1;
			bound_s3 <= bound_s2;
		end
	end

	wire run_pin      = pin_s2[tst_pkg::PIN_RUN];
	wire long_pin     = pin_s2[tst_pkg::PIN_LONG];
	wire master_pin   = pin_s2[tst_pkg::PIN_MASTER];
	wire combined_pin = pin_s2[tst_pkg::PIN_COMBINED];
	wire up_boundary  = bound_s2 ^ bound_s3;

	// ---------------- Slice generator ----------------

	tst_pkg::tst_gen_state_t      gen_state;
	logic                         long_mode;
	logic [tst_pkg::COUNT_W-1:0]  slice_cnt;
	logic                         fwd_phase;

	wire                          running    = (gen_state == tst_pkg::TST_GEN_RUN);
	wire [tst_pkg::COUNT_W-1:0]   slice_len  = long_mode ? tst_pkg::LONG_SLICE_CYCLES : tst_pkg::SHORT_SLICE_CYCLES;
	wire [tst_pkg::COUNT_W-1:0]   slice_last = tst_pkg::COUNT_W'(slice_len - 1'b1);
	// A follower restarts on an upstream boundary, never in a slice's first cycle.
	wire                          resync     = running && !master_pin && up_boundary
	                                           && (slice_cnt != tst_pkg::COUNT_RESET);
	wire                          at_end     = running && ((slice_cnt == slice_last) || resync);
	wire [tst_pkg::COUNT_W-1:0]   next_slice_cnt = at_end ? tst_pkg::COUNT_RESET
	                                              : tst_pkg::COUNT_W'(slice_cnt + 1'b1);

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			gen_state <= tst_pkg::TST_GEN_IDLE;
			long_mode <= 1'b0;
			slice_cnt <= tst_pkg::COUNT_RESET;
		end else begin
			unique case (gen_state)
				tst_pkg::TST_GEN_IDLE: begin
					long_mode <= long_pin;
					slice_cnt <= slice_last;
					if (run_pin) begin
						gen_state <= tst_pkg::TST_GEN_RUN;
					end
				end
				tst_pkg::TST_GEN_RUN: begin
					slice_cnt <= next_slice_cnt;
					if (at_end && !run_pin) begin
						gen_state <= tst_pkg::TST_GEN_IDLE;
					end
				end
			endcase
		end
	end

	// ---------------- Crossing into the FIFO ----------------

	tst_stream_if #(.W(tst_pkg::FIFO_W)) fifo_wr ();
	tst_stream_if #(.W(tst_pkg::FIFO_W)) fifo_rd ();

	wire pending = (req_s2 != sys_ack);

	assign fifo_wr.valid = pending;
	assign fifo_wr.data  = {rx_tag, rx_word};

	// The acknowledge waits for FIFO room, so a full FIFO stalls the link.
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			sys_ack <= 1'b0;
		end else if (pending && fifo_wr.ready) begin
			sys_ack <= ~sys_ack;
		end
	end

	tst_fifo #(
		.W     (tst_pkg::FIFO_W),
		.DEPTH (tst_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.wr      (fifo_wr),
		.rd      (fifo_rd)
	);

	// ---------------- Lane gathering ----------------

	logic [tst_pkg::LANE_CNT_W-1:0]        gather_cnt;
	logic [tst_pkg::TAG_W-1:0]             gather_tag;
	logic [tst_pkg::LANES-1:0]             gather_valid;
	logic [tst_pkg::LANES*tst_pkg::WORD_W-1:0] gather_word;

	wire [tst_pkg::WORD_W-1:0] head_word = fifo_rd.data[tst_pkg::WORD_W-1:0];
	wire [tst_pkg::TAG_W-1:0]  head_tag  = fifo_rd.data[tst_pkg::FIFO_W-1 -: tst_pkg::TAG_W];
	// Short words use only the low half of the lane.
	wire [tst_pkg::WORD_W-1:0] short_mask = {{(tst_pkg::WORD_W-tst_pkg::SHORT_WORD_W){1'b0}},
	                                         {tst_pkg::SHORT_WORD_W{1'b1}}};
	wire [tst_pkg::WORD_W-1:0] lane_in   = long_mode ? head_word : (head_word & short_mask);
	wire                       lanes_room = gather_cnt < tst_pkg::LANES_FULL;
	wire                       tag_match  = (gather_cnt == '0) || (head_tag == gather_tag);
	wire                       take_word  = fifo_rd.valid && running && !at_end && lanes_room && tag_match;

	assign fifo_rd.ready = running && !at_end && lanes_room && tag_match;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			gather_cnt <= '0;
			gather_tag <= '0;
		end else if (at_end) begin
			gather_cnt <= '0;
		end else if (take_word) begin
			gather_cnt <= tst_pkg::LANE_CNT_W'(gather_cnt + 1'b1);
			gather_tag <= head_tag;
		end
	end

	// Each lane carries one word for a whole slice.
	genvar g;
	generate
		for (g = 0; g < tst_pkg::LANES; g++) begin : g_lane
			wire lane_take = take_word && (gather_cnt == tst_pkg::LANE_CNT_W'(g));
			always_ff @(posedge i_clock or negedge i_rstn) begin
				if (!i_rstn) begin
					gather_valid[g]                                 <= 1'b0;
					gather_word[g*tst_pkg::WORD_W +: tst_pkg::WORD_W] <= '0;
				end else if (at_end) begin
					gather_valid[g] <= 1'b0;
				end else if (lane_take) begin
					gather_valid[g]                                 <= 1'b1;
					gather_word[g*tst_pkg::WORD_W +: tst_pkg::WORD_W] <= lane_in;
				end
			end
		end
	endgenerate

	// ---------------- Coincidence stage ----------------

	logic [tst_pkg::PAIRS-1:0]            next_pair_hit;
	logic [tst_pkg::COINC_W-1:0]          next_coinc;
	logic [tst_pkg::UNIT_W-1:0]           unit_a;
	logic [tst_pkg::UNIT_W-1:0]           unit_b;

	// Only lanes gathered within this slice are compared.
	always_comb begin
		next_pair_hit = '0;
		next_coinc    = '0;
		unit_a        = '0;
		unit_b        = '0;
		for (int i = 0; i < tst_pkg::LANES; i++) begin
			for (int j = i + 1; j < tst_pkg::LANES; j++) begin
				unit_a = gather_word[i*tst_pkg::WORD_W + tst_pkg::UNIT_LSB +: tst_pkg::UNIT_W];
				unit_b = gather_word[j*tst_pkg::WORD_W + tst_pkg::UNIT_LSB +: tst_pkg::UNIT_W];
				if (gather_valid[i] && gather_valid[j] && (unit_a != unit_b)) begin
					next_coinc = tst_pkg::COINC_W'(next_coinc + 1'b1);
					if (unit_a < unit_b) begin
						next_pair_hit[tst_pkg::tst_pair_index(unit_a, unit_b)] = 1'b1;
					end else begin
						next_pair_hit[tst_pkg::tst_pair_index(unit_b, unit_a)] = 1'b1;
					end
				end
			end
		end
	end

	wire coinc_enable = combined_pin;

	// Per-pair counters saturate at the most events a pair can yield.
	generate
		for (g = 0; g < tst_pkg::PAIRS; g++) begin : g_pair
			logic [tst_pkg::COUNT_W-1:0] cnt;
			wire  sat = (cnt == tst_pkg::COUNT_W'(tst_pkg::MAX_PER_PAIR));
			always_ff @(posedge i_clock or negedge i_rstn) begin
				if (!i_rstn) begin
					cnt <= '0;
				end else if (at_end) begin
					cnt <= '0;
				end else if (coinc_enable && next_pair_hit[g] && take_word && !sat) begin
					cnt <= tst_pkg::COUNT_W'(cnt + 1'b1);
				end
			end
			always_ff @(posedge i_clock or negedge i_rstn) begin
				if (!i_rstn) begin
					o_pair_count[g*tst_pkg::COUNT_W +: tst_pkg::COUNT_W] <= '0;
				end else if (at_end) begin
					o_pair_count[g*tst_pkg::COUNT_W +: tst_pkg::COUNT_W] <= cnt;
				end
			end
		end
	endgenerate

	// Results of one slice are registered at its end and stand a whole slice.
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pair_hit    <= '0;
			o_coinc_count <= '0;
		end else if (at_end) begin
			o_pair_hit    <= coinc_enable ? next_pair_hit : '0;
			o_coinc_count <= coinc_enable ? next_coinc : '0;
		end
	end

	// ---------------- Output lanes and forwarded timing ----------------

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tx_valid <= '0;
			o_tx_word  <= '0;
		end else if (at_end) begin
			o_tx_valid <= gather_valid;
			o_tx_word  <= gather_word;
		end
	end

	// The forwarded copies leave on the same edge as the lane data.
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_slice_strobe <= 1'b0;
			o_fwd_strobe   <= 1'b0;
			fwd_phase      <= 1'b0;
			o_fwd_clock    <= 1'b0;
		end else begin
			o_slice_strobe <= at_end;
			o_fwd_strobe   <= at_end;
			fwd_phase      <= at_end ? 1'b1 : ~fwd_phase;
			o_fwd_clock    <= at_end ? 1'b1 : ~fwd_phase;
		end
	end

	// Dead time equals the slice length, halved in short mode.
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_long_active <= 1'b0;
			o_dead_cycles <= tst_pkg::SHORT_SLICE_CYCLES;
		end else begin
			o_long_active <= long_mode;
			o_dead_cycles <= slice_len;
		end
	end

endmodule : tst_top
`default_nettype wire

//--- verification/tst_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tst_checker (
	input wire logic                                  i_clock,
	input wire logic                                  i_rstn,
	input wire logic                                  i_link_clock,
	input wire logic                                  i_run,
	input wire logic                                  i_timing_master,
	input wire logic                                  i_combined_role,
	input wire logic                                  i_link_valid,
	input wire logic                                  o_link_ready,
	input wire logic                                  o_slice_strobe,
	input wire logic                                  o_fwd_clock,
	input wire logic                                  o_fwd_strobe,
	input wire logic [tst_pkg::LANES-1:0]             o_tx_valid,
	input wire logic [tst_pkg::LANES*tst_pkg::WORD_W-1:0] o_tx_word,
	input wire logic                                  o_long_active,
	input wire logic [tst_pkg::COUNT_W-1:0]           o_dead_cycles,
	input wire logic [tst_pkg::COINC_W-1:0]           o_coinc_count
);
	sequence s_go;
		i_run && i_timing_master;
	endsequence
	sequence s_steady(bit lng);
		o_slice_strobe && i_timing_master && o_long_active == lng && $past(i_run, 3);
	endsequence
	sequence s_fwd;
		o_fwd_clock ##1 !o_fwd_clock ##1 o_fwd_clock;
	endsequence

	AST_STROBE_WIDTH: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_slice_strobe |=> !o_slice_strobe) else $error("Strobe wider than one cycle.");
	AST_SHORT_GAP: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_slice_strobe && i_timing_master && !o_long_active |=> !o_slice_strobe[*7])
		else $error("Short slice ended early.");
	AST_SHORT_PERIOD: assert property (@(posedge i_clock) disable iff (!i_rstn)
		s_steady(1'b0) ##1 s_go[*7] |=> o_slice_strobe) else $error("Short slice too long.");
	AST_LONG_GAP: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_slice_strobe && i_timing_master && o_long_active |=> !o_slice_strobe[*8] ##1 !o_slice_strobe[*7])
		else $error("Long slice ended early.");
	AST_LONG_PERIOD: assert property (@(posedge i_clock) disable iff (!i_rstn)
		s_steady(1'b1) ##1 s_go[*8] ##1 s_go[*7] |=> o_slice_strobe) else $error("Long slice too long.");
	AST_FWD_STROBE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_fwd_strobe == o_slice_strobe) else $error("Forwarded strobe differs.");
	AST_FWD_CLOCK: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_slice_strobe |-> s_fwd) else $error("Forwarded clock misaligned.");
	AST_TX_HOLD: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!o_slice_strobe |-> $stable(o_tx_valid) && $stable(o_tx_word)) else $error("Lane changed mid slice.");
	AST_DEAD_TIME: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_dead_cycles == (o_long_active ? tst_pkg::LONG_SLICE_CYCLES : tst_pkg::SHORT_SLICE_CYCLES))
		else $error("Dead time does not match mode.");
	AST_COINC_OFF: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_slice_strobe && !$past(i_combined_role, 2) && !$past(i_combined_role, 3) |-> o_coinc_count == '0)
		else $error("Coincidences while role off.");
	AST_LINK_TAKE: assert property (@(posedge i_link_clock) disable iff (!i_rstn)
		i_link_valid && o_link_ready |=> !o_link_ready) else $error("Link ready held after take.");
endmodule : tst_checker

bind tst_top tst_checker u_tst_checker (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_link_clock(i_link_clock), .i_run(i_run),
	.i_timing_master(i_timing_master), .i_combined_role(i_combined_role), .i_link_valid(i_link_valid),
	.o_link_ready(o_link_ready), .o_slice_strobe(o_slice_strobe), .o_fwd_clock(o_fwd_clock),
	.o_fwd_strobe(o_fwd_strobe), .o_tx_valid(o_tx_valid), .o_tx_word(o_tx_word),
	.o_long_active(o_long_active), .o_dead_cycles(o_dead_cycles), .o_coinc_count(o_coinc_count)
);
`default_nettype wire

//--- verification/tst_link_src.sv
`timescale 1ns/1ps
`default_nettype none
module tst_link_src #(
	parameter int STROBE_EVERY = 3
) (
	input  wire logic                       i_link_clock,
	input  wire logic                       i_rstn,
	input  wire logic                       i_offer,
	input  wire logic [tst_pkg::WORD_W-1:0] i_next_word,
	input  wire logic                       i_ready,
	output logic                            o_strobe,
	output logic                            o_valid,
	output logic [tst_pkg::WORD_W-1:0]      o_word
);
	int tick;

	always @(posedge i_link_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			tick <= 0;
			o_strobe <= 1'b0;
			o_valid <= 1'b0;
			o_word <= '0;
		end else begin
			tick <= (tick == STROBE_EVERY) ? 0 : tick + 1;
			o_strobe <= (tick == STROBE_EVERY);
			if (o_valid && i_ready) begin
				o_valid <= 1'b0;
				o_word <= ~o_word;
			end else if (!o_valid && i_offer) begin
				o_valid <= 1'b1;
				o_word <= i_next_word;
			end else if (!o_valid) begin
				// An idle word line keeps changing so no stale value looks valid.
				o_word <= ~o_word;
			end
		end
	end
endmodule : tst_link_src
`default_nettype wire

//--- verification/time_slice_timing_bench.sv
`timescale 1ns/1ps
`default_nettype none
module time_slice_timing_bench;
	logic                                      clock = 1'b0;
	logic                                      link_clock = 1'b0;
	logic                                      rstn = 1'b0;
	logic                                      long_mode = 1'b0;
	logic                                      run = 1'b0;
	logic                                      master = 1'b1;
	logic                                      role = 1'b1;
	logic                                      offer = 1'b0;
	logic [tst_pkg::WORD_W-1:0]                next_word = '0;
	logic                                      link_strobe;
	logic                                      link_valid;
	logic [tst_pkg::WORD_W-1:0]                link_word;
	logic                                      link_ready;
	logic                                      slice_strobe;
	logic                                      fwd_strobe;
	logic [tst_pkg::LANES-1:0]                 tx_valid;
	logic [tst_pkg::LANES*tst_pkg::WORD_W-1:0] tx_word;
	logic                                      long_active;
	logic [tst_pkg::COUNT_W-1:0]               dead_cycles;
	logic [tst_pkg::COINC_W-1:0]               coinc_count;
	logic [tst_pkg::PAIRS-1:0]                 pair_hit;
	logic [tst_pkg::PAIRS-1:0]                 hit_exp;
	logic [tst_pkg::PAIRS*tst_pkg::COUNT_W-1:0] pair_count;
	logic [tst_pkg::UNIT_W-1:0]                units[tst_pkg::LANES];
	int                                        pc[tst_pkg::PAIRS];
	int                                        n_lanes, n_pairs;
	logic [tst_pkg::WORD_W-1:0]                sent[$];
	logic [tst_pkg::WORD_W-1:0]                w;
	int                                        n_errors = 0;
	int                                        check_count = 0;
	int                                        gap = 0;
	bit                                        have = 1'b0;
	bit                                        steady = 1'b0;

	tst_top u_tst_top (.i_clock(clock), .i_rstn(rstn), .i_link_clock(link_clock), .i_long_mode(long_mode),
		.i_run(run), .i_timing_master(master), .i_combined_role(role), .i_link_strobe(link_strobe),
		.i_link_valid(link_valid), .i_link_word(link_word), .o_link_ready(link_ready),
		.o_slice_strobe(slice_strobe), .o_fwd_clock(), .o_fwd_strobe(fwd_strobe), .o_tx_valid(tx_valid),
		.o_tx_word(tx_word), .o_long_active(long_active), .o_dead_cycles(dead_cycles), .o_pair_hit(pair_hit),
		.o_pair_count(pair_count), .o_coinc_count(coinc_count));
	tst_link_src u_tst_link_src (.i_link_clock(link_clock), .i_rstn(rstn), .i_offer(offer),
		.i_next_word(next_word), .i_ready(link_ready), .o_strobe(link_strobe), .o_valid(link_valid),
		.o_word(link_word));

	always #2 clock = ~clock;
	initial begin
		#1.3;
		forever begin
			link_clock = ~link_clock;
			#32;
		end
	end

	function automatic int slice_len(input bit lng);
		return lng ? int'(tst_pkg::LONG_SLICE_CYCLES) : int'(tst_pkg::SHORT_SLICE_CYCLES);
	endfunction : slice_len

	// Short mode carries only the lower half of each word.
	function automatic logic [tst_pkg::WORD_W-1:0] lane_exp(input logic [tst_pkg::WORD_W-1:0] v, input bit lng);
		return lng ? v : v & ((32'h1 << tst_pkg::SHORT_WORD_W) - 32'h1);
	endfunction : lane_exp

	function automatic int pair_idx(input int a, input int b);
		int k = 0;
		for (int x = 0; x < tst_pkg::UNITS; x++) begin
			for (int y = x + 1; y < tst_pkg::UNITS; y++) begin
				if ((x == a && y == b) || (x == b && y == a))
					return k;
				k = k + 1;
			end
		end
		return 0;
	endfunction : pair_idx

	task automatic check(input logic [tst_pkg::WORD_W-1:0] seen, input logic [tst_pkg::WORD_W-1:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("Checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	always @(negedge link_clock) begin
		if (rstn && link_valid && link_ready)
			sent.push_back(link_word);
	end

	always @(negedge clock) begin
		gap = gap + 1;
		if (slice_strobe === 1'b1) begin
			check(fwd_strobe, 1'b1);
			if (steady && have && master)
				check(gap, slice_len(long_mode));
			if (steady && have && !master)
				check(32'(gap <= slice_len(long_mode)), 32'h1);
			n_lanes = 0;
			n_pairs = 0;
			hit_exp = '0;
			for (int p = 0; p < tst_pkg::PAIRS; p++)
				pc[p] = 0;
			for (int g = 0; g < tst_pkg::LANES; g++) begin
				if (tx_valid[g] === 1'b1) begin
					w = (sent.size() > 0) ? sent.pop_front() : 'x;
					check(tx_word[g*tst_pkg::WORD_W +: tst_pkg::WORD_W], lane_exp(w, long_mode));
					for (int p = 0; p < tst_pkg::PAIRS; p++)
						pc[p] = pc[p] + int'(hit_exp[p]);
					for (int i = 0; i < n_lanes; i++) begin
						if (units[i] != w[2:0]) begin
							n_pairs = n_pairs + 1;
							hit_exp[pair_idx(units[i], w[2:0])] = 1'b1;
						end
					end
					units[n_lanes] = w[2:0];
					n_lanes = n_lanes + 1;
				end
			end
			check(coinc_count, role ? 32'(n_pairs) : 32'h0);
			check(pair_hit, role ? hit_exp : '0);
			for (int p = 0; p < tst_pkg::PAIRS; p++)
				check(pair_count[p*tst_pkg::COUNT_W +: tst_pkg::COUNT_W], role ? pc[p] : 0);
			have = 1'b1;
			gap = 0;
		end
	end

	task automatic do_reset(input int n);
		rstn = 1'b0;
		sent.delete();
		have = 1'b0;
		repeat (n) @(posedge clock);
		#1;
		check(link_ready, 1'b1);
		check(dead_cycles, tst_pkg::SHORT_SLICE_CYCLES);
		check(slice_strobe, 1'b0);
		rstn = 1'b1;
	endtask : do_reset

	task automatic drain();
		offer = 1'b0;
		repeat (300) @(posedge clock);
		#1;
		check(32'(sent.size()), 32'h0);
	endtask : drain

	// Floods the link while stopped so the buffer refuses, then runs with random traffic.
	task automatic phase(input bit lng, input bit mst, input bit rl, input int n);
		drain();
		steady = 1'b0;
		run = 1'b0;
		repeat (40) @(posedge clock);
		#1;
		long_mode = lng;
		master = mst;
		role = rl;
		offer = 1'b1;
		repeat (400) begin
			@(posedge clock);
			#1;
			next_word = $urandom;
		end
		check(link_ready, 1'b0);
		have = 1'b0;
		run = 1'b1;
		repeat (20) @(posedge clock);
		#1;
		steady = 1'b1;
		repeat (n) begin
			@(posedge clock);
			#1;
			offer = ($urandom_range(3) != 0);
			next_word = $urandom;
		end
		check(long_active, lng);
		check(dead_cycles, slice_len(lng));
	endtask : phase

	initial begin
		#80000;
		n_errors = n_errors + 1;
		stop_test();
	end

	initial begin
		void'($urandom(32'hE6A6));
		do_reset(2);
		phase(1'b0, 1'b1, 1'b1, 600);
		phase(1'b1, 1'b1, 1'b0, 600);
		do_reset(40);
		phase(1'b0, 1'b0, 1'b1, 400);
		drain();
		stop_test();
	end
endmodule : time_slice_timing_bench
`default_nettype wire
